// ===== design/field_threshold_and_am_drive_regs.sv
// Register bank for field detect thresholds and resistive AM driver setup
//
// Contract
// - Threshold register: bit7 zero, peer 6:4, collision 3:0
// - Modulation register in space B, resets zero
// - Bit 7 selects minimum driver non-overlap
// - Bits 6:0 set modulated-state driver resistance
// - Resistance code maps monotonically to normalized value
`default_nettype none
module field_threshold_and_am_drive_regs
  import field_am_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // APB slave
  input wire apb_req_t APB_REQ,
  output apb_rsp_t APB_RSP,
  // Analog front end status
  input wire logic AM_MOD_ACTIVE,
  input wire logic DEACT_COLL_MSB,
  // Threshold controls
  output logic [2:0] PEER_DET_LEVEL,
  output logic [3:0] COLL_AVOID_LEVEL,
  output logic THRESH_MSB_MISMATCH,
  // Driver controls
  output logic MIN_NONOVERLAP_SEL,
  output logic [RES_CODE_W-1:0] MODULATED_DRIVE_RES_CODE,
  output logic [RES_CODE_W-1:0] DRIVE_RES_CODE,
  output logic [RES_NORM_W-1:0] DRIVE_RES_NORM
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Only exact word addresses hit; anything else answers with an error
  function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == THRESH_ADDR) begin
      sel = SEL_THRESH;
    end else if (addr == RESAM_ADDR) begin
      sel = SEL_RESAM;
    end else if (addr == STATUS_ADDR) begin
      sel = SEL_STATUS;
    end else begin
      sel = SEL_NONE;
    end
    return sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State declarations

  apb_phase_t phase;
  apb_phase_t next_phase;
  reg_sel_t sel;
  reg_sel_t next_sel;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic err;
  logic next_err;

  thresh_t thresh;
  thresh_t next_thresh;
  resam_t resam;
  resam_t next_resam;

  logic [RES_CODE_W-1:0] drive_code;
  logic [RES_CODE_W-1:0] next_drive_code;
  logic [RES_NORM_W-1:0] drive_norm;
  logic [RES_NORM_W-1:0] next_drive_norm;
  logic mismatch;
  logic next_mismatch;
  logic mod_active;
  logic next_mod_active;

  logic [RES_NORM_W-1:0] rom_norm;
  logic setup_phase;
  logic access_phase;
  logic write_commit;
  logic lane0_en;
  reg_sel_t setup_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase qualifiers

  always_comb begin
    setup_phase = APB_REQ.psel && !APB_REQ.penable;
    access_phase = APB_REQ.psel && APB_REQ.penable && (phase == PH_ACCESS);
    setup_sel = decode_addr(APB_REQ.paddr);
    lane0_en = APB_REQ.pstrb[0];
    // Write lands only on the access edge and only if setup found it legal
    write_commit = access_phase && APB_REQ.pwrite && !err;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB phase machine

  // Answer is prepared in setup so read data leaves a flip-flop
  always_comb begin
    next_phase = phase;
    next_sel = sel;
    next_rdata = rdata;
    next_err = err;
    case (phase)
      PH_IDLE: begin
        if (setup_phase) begin
          next_phase = PH_ACCESS;
          next_sel = setup_sel;
          next_err = (setup_sel == SEL_NONE) || (APB_REQ.pwrite && setup_sel == SEL_STATUS);
          next_rdata = '0;
          if (!APB_REQ.pwrite) begin
            if (setup_sel == SEL_THRESH) begin
              next_rdata = {24'h000000, 1'b0, thresh.peer_det_level, thresh.coll_avoid_level};
            end else if (setup_sel == SEL_RESAM) begin
              next_rdata = {24'h000000, resam};
            end else if (setup_sel == SEL_STATUS) begin
              next_rdata[STAT_MISMATCH_BIT] = mismatch;
              next_rdata[STAT_MODACT_BIT] = mod_active;
              next_rdata[STAT_CODE_LSB +: RES_CODE_W] = drive_code;
              next_rdata[RES_NORM_W-1:0] = drive_norm;
            end else begin
              next_rdata = '0;
            end
          end
        end
      end
      PH_ACCESS: begin
        if (access_phase) begin
          next_phase = PH_IDLE;
          next_sel = SEL_NONE;
        end else if (!APB_REQ.psel) begin
          // Master abandoned the transfer; drop it quietly
          next_phase = PH_IDLE;
          next_sel = SEL_NONE;
          next_err = 1'b0;
        end
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      phase <= PH_IDLE;
      sel <= SEL_NONE;
      rdata <= '0;
      err <= 1'b0;
    end else begin
      phase <= next_phase;
      sel <= next_sel;
      rdata <= next_rdata;
      err <= next_err;
    end
  end

  // Zero-wait slave: ready in the first access cycle
  always_comb begin
    APB_RSP.pready = (phase == PH_ACCESS);
    APB_RSP.pslverr = (phase == PH_ACCESS) && err;
    APB_RSP.prdata = rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Only byte lane 0 carries these 8-bit registers
  always_comb begin
    next_thresh = thresh;
    next_resam = resam;
    if (write_commit && lane0_en) begin
      if (sel == SEL_THRESH) begin
        next_thresh.rsvd = 1'b0;
        next_thresh.peer_det_level = APB_REQ.pwdata[PEER_LSB +: 3];
        next_thresh.coll_avoid_level = APB_REQ.pwdata[COLL_LSB +: 4];
      end else if (sel == SEL_RESAM) begin
        next_resam.min_nonoverlap_sel = APB_REQ.pwdata[MINOVL_BIT];
        next_resam.modulated_drive_res_code = APB_REQ.pwdata[RES_CODE_W-1:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      thresh <= thresh_t'(THRESH_RST);
      resam <= resam_t'(RESAM_RST);
    end else begin
      thresh <= next_thresh;
      resam <= next_resam;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver resistance selection

  res_norm_rom #(
    .RES_W(RES_NORM_W)
  ) u_rom (
    .code(next_drive_code),
    .res_milli(rom_norm)
  );

  // Programmed code only reaches the driver in the modulated state
  always_comb begin
    next_mod_active = AM_MOD_ACTIVE;
    if (AM_MOD_ACTIVE) begin
      next_drive_code = resam.modulated_drive_res_code;
    end else begin
      next_drive_code = DRIVE_CODE_RST;
    end
    next_drive_norm = rom_norm;
  end

  // Collision MSB must agree with the deactivation copy; flag a slip
  always_comb begin
    next_mismatch = thresh.coll_avoid_level[COLL_MSB] != DEACT_COLL_MSB;
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      drive_code <= DRIVE_CODE_RST;
      drive_norm <= DRIVE_NORM_RST;
      mismatch <= 1'b0;
      mod_active <= 1'b0;
    end else begin
      drive_code <= next_drive_code;
      drive_norm <= next_drive_norm;
      mismatch <= next_mismatch;
      mod_active <= next_mod_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    PEER_DET_LEVEL = thresh.peer_det_level;
    COLL_AVOID_LEVEL = thresh.coll_avoid_level;
    THRESH_MSB_MISMATCH = mismatch;
    MIN_NONOVERLAP_SEL = resam.min_nonoverlap_sel;
    MODULATED_DRIVE_RES_CODE = resam.modulated_drive_res_code;
    DRIVE_RES_CODE = drive_code;
    DRIVE_RES_NORM = drive_norm;
  end

endmodule
`default_nettype wire

// ===== include/field_am_pkg.sv
// Package: register map, field layout, reset values and bus carriers for the field threshold and AM drive block
`default_nettype none
package field_am_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Printed register indices; byte address is four times the index
  localparam logic [7:0] THRESH_IDX = 8'h2A;
  localparam logic [7:0] RESAM_IDX = 8'h2A;

  // Space B sits one window above space A
  localparam logic [ADDR_W-1:0] SPACE_B_BASE = 12'h200;
  localparam logic [ADDR_W-1:0] THRESH_ADDR = {2'b00, THRESH_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] RESAM_ADDR = SPACE_B_BASE | {2'b00, RESAM_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h300;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int PEER_LSB = 4;
  localparam int COLL_LSB = 0;
  localparam int COLL_MSB = 3;
  localparam int MINOVL_BIT = 7;
  localparam int RES_CODE_W = 7;
  localparam int RES_NORM_W = 16;
  localparam int STAT_MISMATCH_BIT = 31;
  localparam int STAT_MODACT_BIT = 24;
  localparam int STAT_CODE_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] THRESH_RST = 8'h33;
  localparam logic [7:0] RESAM_RST = 8'h00;
  localparam logic [RES_CODE_W-1:0] DRIVE_CODE_RST = 7'h00;
  localparam logic [RES_NORM_W-1:0] DRIVE_NORM_RST = 16'h03EC;

  ////////////////////////////////////////////////////////////////////////////
  // Register layouts
  typedef struct packed {
    logic rsvd;
    logic [2:0] peer_det_level;
    logic [3:0] coll_avoid_level;
  } thresh_t;

  typedef struct packed {
    logic min_nonoverlap_sel;
    logic [RES_CODE_W-1:0] modulated_drive_res_code;
  } resam_t;

  ////////////////////////////////////////////////////////////////////////////
  // APB carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef enum {SEL_NONE, SEL_THRESH, SEL_RESAM, SEL_STATUS} reg_sel_t;
  typedef enum {PH_IDLE, PH_ACCESS} apb_phase_t;

endpackage
`default_nettype wire

// ===== design/res_norm_rom.sv
// Lookup of normalized modulated-state driver resistance, in thousandths
`default_nettype none
module res_norm_rom
  import field_am_pkg::*;
#(
  parameter int RES_W = 16
) (
  // Code in
  input wire logic [RES_CODE_W-1:0] code,
  // Resistance out, thousandths
  output logic [RES_W-1:0] res_milli
);

  // Sixteen bits hold the largest entry
  if (RES_W < 16) begin : g_width_check
    $error("res_norm_rom needs RES_W of at least 16");
  end

  // Strictly rising so the code maps monotonically
  localparam logic [15:0] TABLE [128] = '{
    16'd1004, 16'd1020, 16'd1036, 16'd1053, 16'd1071, 16'd1089, 16'd1108, 16'd1128,
    16'd1148, 16'd1169, 16'd1191, 16'd1213, 16'd1237, 16'd1261, 16'd1286, 16'd1313,
    16'd1340, 16'd1369, 16'd1399, 16'd1430, 16'd1463, 16'd1497, 16'd1533, 16'd1571,
    16'd1610, 16'd1652, 16'd1695, 16'd1741, 16'd1790, 16'd1842, 16'd1896, 16'd1954,
    16'd2016, 16'd2081, 16'd2151, 16'd2226, 16'd2306, 16'd2349, 16'd2393, 16'd2438,
    16'd2485, 16'd2535, 16'd2586, 16'd2639, 16'd2695, 16'd2753, 16'd2813, 16'd2876,
    16'd2943, 16'd3012, 16'd3084, 16'd3160, 16'd3241, 16'd3325, 16'd3413, 16'd3507,
    16'd3570, 16'd3630, 16'd3690, 16'd3750, 16'd3810, 16'd3870, 16'd3930, 16'd3995,
    16'd4063, 16'd4129, 16'd4197, 16'd4267, 16'd4339, 16'd4414, 16'd4491, 16'd4571,
    16'd4655, 16'd4741, 16'd4830, 16'd4923, 16'd5020, 16'd5120, 16'd5224, 16'd5333,
    16'd5447, 16'd5565, 16'd5689, 16'd5818, 16'd5953, 16'd6095, 16'd6244, 16'd6400,
    16'd6564, 16'd6737, 16'd6919, 16'd7111, 16'd7314, 16'd7529, 16'd7758, 16'd8000,
    16'd8258, 16'd8533, 16'd8828, 16'd9143, 16'd9481, 16'd9846, 16'd10240, 16'd10670,
    16'd11130, 16'd11640, 16'd12190, 16'd12800, 16'd13470, 16'd14220, 16'd15060, 16'd16000,
    16'd17070, 16'd18290, 16'd19690, 16'd21300, 16'd23300, 16'd25600, 16'd28400, 16'd32000,
    16'd36600, 16'd42700, 16'd51200, 16'd54000, 16'd57000, 16'd60000, 16'd63000, 16'd65535
  };

  always_comb begin
    res_milli = RES_W'(TABLE[code]);
  end

endmodule
`default_nettype wire

// ===== verification/field_am_props.sv
// Checker for the field threshold and AM drive register bank
`default_nettype none
module field_am_props
  import field_am_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Bus
  input wire apb_req_t APB_REQ,
  input wire apb_rsp_t APB_RSP,
  // Controls
  input wire logic AM_MOD_ACTIVE,
  input wire logic [2:0] PEER_DET_LEVEL,
  input wire logic [3:0] COLL_AVOID_LEVEL,
  input wire logic MIN_NONOVERLAP_SEL,
  input wire logic [RES_CODE_W-1:0] MODULATED_DRIVE_RES_CODE,
  input wire logic [RES_CODE_W-1:0] DRIVE_RES_CODE,
  input wire logic [RES_NORM_W-1:0] DRIVE_RES_NORM
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////
  // Byte lane 0 carries both registers
  logic wr_done;
  assign wr_done = APB_REQ.psel && APB_REQ.penable && APB_RSP.pready && APB_REQ.pwrite && APB_REQ.pstrb[0];
  thresh_write_a: assert property (
    wr_done && APB_REQ.paddr == THRESH_ADDR |=>
    {PEER_DET_LEVEL, COLL_AVOID_LEVEL} == $past(APB_REQ.pwdata[6:0])) else $error("threshold write lost");
  rst_thresh_a: assert property (
    $rose(RST_B) |-> PEER_DET_LEVEL == 3'h3 && COLL_AVOID_LEVEL == 4'h3) else $error("threshold reset wrong");
  rst_mod_a: assert property (
    $rose(RST_B) |-> {MIN_NONOVERLAP_SEL, MODULATED_DRIVE_RES_CODE} == 8'h00) else $error("mod reset wrong");
  mod_write_a: assert property (
    wr_done && APB_REQ.paddr == RESAM_ADDR |=>
    {MIN_NONOVERLAP_SEL, MODULATED_DRIVE_RES_CODE} == $past(APB_REQ.pwdata[7:0])) else $error("mod write lost");
  drive_idle_a: assert property (
    !AM_MOD_ACTIVE |=> DRIVE_RES_CODE == 7'h00) else $error("drive code not idle");
  drive_follow_a: assert property (
    AM_MOD_ACTIVE && $stable(MODULATED_DRIVE_RES_CODE) ##1 $stable(MODULATED_DRIVE_RES_CODE) |->
    DRIVE_RES_CODE == MODULATED_DRIVE_RES_CODE) else $error("drive code not following");
  norm_zero_a: assert property (
    DRIVE_RES_CODE == 7'h00 |-> DRIVE_RES_NORM == 16'h03EC) else $error("code zero norm wrong");
  norm_mono_a: assert property (
    DRIVE_RES_CODE > $past(DRIVE_RES_CODE) |-> DRIVE_RES_NORM > $past(DRIVE_RES_NORM)) else $error("norm not rising");
  ////////////////////////////////////////
  cover property (wr_done && APB_REQ.paddr == RESAM_ADDR);
  cover property (AM_MOD_ACTIVE && DRIVE_RES_CODE == 7'h40);
  cover property (APB_RSP.pready && APB_RSP.pslverr);
endmodule
bind field_threshold_and_am_drive_regs field_am_props u_props (
  .CLK_SYS(CLK_SYS),
  .RST_B(RST_B),
  .APB_REQ(APB_REQ),
  .APB_RSP(APB_RSP),
  .AM_MOD_ACTIVE(AM_MOD_ACTIVE),
  .PEER_DET_LEVEL(PEER_DET_LEVEL),
  .COLL_AVOID_LEVEL(COLL_AVOID_LEVEL),
  .MIN_NONOVERLAP_SEL(MIN_NONOVERLAP_SEL),
  .MODULATED_DRIVE_RES_CODE(MODULATED_DRIVE_RES_CODE),
  .DRIVE_RES_CODE(DRIVE_RES_CODE),
  .DRIVE_RES_NORM(DRIVE_RES_NORM)
);
`default_nettype wire

// ===== verification/field_threshold_and_am_drive_regs_tb.sv
// Testbench for the field threshold and AM drive register bank
`default_nettype none
module field_threshold_and_am_drive_regs_tb
  import field_am_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS, RST_B, AM_MOD_ACTIVE, DEACT_COLL_MSB;
  apb_req_t APB_REQ;
  apb_rsp_t APB_RSP;
  logic [2:0] PEER_DET_LEVEL;
  logic [3:0] COLL_AVOID_LEVEL;
  logic THRESH_MSB_MISMATCH, MIN_NONOVERLAP_SEL;
  logic [6:0] MODULATED_DRIVE_RES_CODE, DRIVE_RES_CODE;
  logic [15:0] DRIVE_RES_NORM;
  int errors = 0;
  int n_compared = 0;
  logic [31:0] rd_data;
  logic rd_err;
  field_threshold_and_am_drive_regs uut (
    .CLK_SYS(CLK_SYS),
    .RST_B(RST_B),
    .APB_REQ(APB_REQ),
    .APB_RSP(APB_RSP),
    .AM_MOD_ACTIVE(AM_MOD_ACTIVE),
    .DEACT_COLL_MSB(DEACT_COLL_MSB),
    .PEER_DET_LEVEL(PEER_DET_LEVEL),
    .COLL_AVOID_LEVEL(COLL_AVOID_LEVEL),
    .THRESH_MSB_MISMATCH(THRESH_MSB_MISMATCH),
    .MIN_NONOVERLAP_SEL(MIN_NONOVERLAP_SEL),
    .MODULATED_DRIVE_RES_CODE(MODULATED_DRIVE_RES_CODE),
    .DRIVE_RES_CODE(DRIVE_RES_CODE),
    .DRIVE_RES_NORM(DRIVE_RES_NORM)
  );
  initial begin
    CLK_SYS = 1'b0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Request stands until pready is seen high at a rising edge; answer taken at that edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    APB_REQ <= '{1'b1, 1'b0, w, a, d, 4'hF};
    @(posedge CLK_SYS);
    APB_REQ.penable <= 1'b1;
    @(posedge CLK_SYS);
    while (APB_RSP.pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge CLK_SYS);
    end
    if (n >= 20) begin
      errors++;
      $display("unexpected at %0t: pready got %h exp %h", $time, 1'b0, 1'b1);
    end
    rd_data = APB_RSP.prdata;
    rd_err = APB_RSP.pslverr;
    APB_REQ <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd_data, exp);
    chk(32'(rd_err), 32'h0);
  endtask
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100us;
    errors++;
    close_out();
  end
  ////////////////////////////////////////
  logic [6:0] codes [3] = '{7'h00, 7'h10, 7'h40};
  logic [15:0] norms [3] = '{16'h03EC, 16'h053C, 16'h0FDF};
  initial begin
    RST_B = 1'b0;
    APB_REQ = '0;
    AM_MOD_ACTIVE = 1'b0;
    DEACT_COLL_MSB = 1'b0;
    repeat (10) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    rd(THRESH_ADDR, 32'h33);
    rd(RESAM_ADDR, 32'h00);
    $display("reset test done");
    xfer(1'b1, THRESH_ADDR, 32'hFFFF_FFFF);
    rd(THRESH_ADDR, 32'h7F);
    chk(32'({PEER_DET_LEVEL, COLL_AVOID_LEVEL}), 32'h7F);
    chk(32'(THRESH_MSB_MISMATCH), 32'h1);
    // Software brings the deactivation copy back in line
    @(posedge CLK_SYS) DEACT_COLL_MSB <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    chk(32'(THRESH_MSB_MISMATCH), 32'h0);
    xfer(1'b1, RESAM_ADDR, 32'hA5);
    rd(RESAM_ADDR, 32'hA5);
    chk(32'({MIN_NONOVERLAP_SEL, MODULATED_DRIVE_RES_CODE}), 32'hA5);
    rd(THRESH_ADDR, 32'h7F);
    $display("field test done");
    @(posedge CLK_SYS) AM_MOD_ACTIVE <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, RESAM_ADDR, 32'(codes[i]));
      repeat (2) @(posedge CLK_SYS);
      chk(32'(MIN_NONOVERLAP_SEL), 32'h0);
      chk(32'(DRIVE_RES_CODE), 32'(codes[i]));
      chk(32'(DRIVE_RES_NORM), 32'(norms[i]));
    end
    rd(STATUS_ADDR, 32'h0140_0FDF);
    @(posedge CLK_SYS) AM_MOD_ACTIVE <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    chk(32'(DRIVE_RES_CODE), 32'h0);
    chk(32'(DRIVE_RES_NORM), 32'h03EC);
    $display("drive test done");
    xfer(1'b0, 12'h0AC, 32'h0);
    chk({rd_data[30:0], rd_err}, 32'h1);
    xfer(1'b1, STATUS_ADDR, 32'hFFFF_FFFF);
    chk(32'(rd_err), 32'h1);
    rd(RESAM_ADDR, 32'h40);
    $display("refusal test done");
    close_out();
  end
endmodule
`default_nettype wire
